// *** core/owd_device.sv ***
/*
 * Dimming receiver end: decodes the self-timed two-byte frame on the
 * control line, holds the five-bit level and returns the acknowledge pulse.
 * Assumes the line reaches it through owd_if and ref_clk runs at 200 MHz.
 */
`timescale 1ns/10ps
module owd_device
   import owd_pkg::*;
#(
   parameter logic [7:0] DEV_ADDR = DEV_ADDR_DEFAULT,
   parameter int ACK_PULSE = ACK_PULSE_CYC,
   parameter int SHUT_TIME = SHUT_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   owd_if.dev line,
   output logic [LEVEL_W-1:0] level,
   output logic shutdownMode,
   output logic frameOk,
   output logic ackActive
);
   typedef enum logic [2:0] {OWD_IDLE, OWD_BIT, OWD_EOS, OWD_ACKWAIT, OWD_ACK, OWD_SHUT} owd_dstate_t;

   owd_dstate_t state_reg, state_next;
   logic syncA_reg, syncB_reg, prev_reg;
   logic [CNT_W-1:0] lowCnt_reg, lowCnt_next;
   logic [CNT_W-1:0] highCnt_reg, highCnt_next;
   logic [CNT_W-1:0] lowRun_reg;
   logic [CNT_W-1:0] timer_reg, timer_next;
   logic [4:0] bitCnt_reg, bitCnt_next;
   logic [FRAME_BITS-1:0] shift_reg, shift_next;
   logic err_reg, err_next;
   logic [LEVEL_W-1:0] level_reg, level_next;
   logic frameOk_reg, frameOk_next;

   // only the second stage is looked at
   wire lineNow = syncB_reg;
   wire fallEdge = prev_reg & !lineNow;
   wire riseEdge = !prev_reg & lineNow;

   // ratios compared on widened counts, no rate setting needed
   wire [CNT_W:0] lowX2 = {lowCnt_reg, 1'b0};
   wire [CNT_W:0] highX2 = {highCnt_reg, 1'b0};
   wire isOne = {1'b0, highCnt_reg} >= lowX2;
   wire isZero = {1'b0, lowCnt_reg} >= highX2;
   wire bitBad = !(isOne ^ isZero);
   wire [FRAME_BITS-1:0] shiftIn = {shift_reg[FRAME_BITS-2:0], isOne};
   wire [4:0] bitCntInc = bitCnt_reg + 5'h01;
   wire errWithBit = err_reg | bitBad;

   wire addrMatch = shiftIn[FRAME_BITS-1:BYTE_BITS] == DEV_ADDR;
   wire subZero = !shiftIn[SUB_HI_BIT] & !shiftIn[SUB_LO_BIT];
   wire frameGood = !errWithBit & addrMatch & subZero;
   wire ackWanted = frameGood & shiftIn[ACK_REQ_BIT];
   wire byteDone = bitCntInc == 5'(BYTE_BITS);
   wire frameDone = bitCntInc == 5'(FRAME_BITS);
   wire longLow = !lineNow & (lowRun_reg > CNT_W'(SHUT_TIME));
   wire eosShort = lowRun_reg < CNT_W'(EOS_CYC);
   wire delayDone = timer_reg == CNT_W'(ACK_DELAY_CYC - 1);
   wire pulseDone = timer_reg == CNT_W'(ACK_PULSE - 1);
   wire [CNT_W-1:0] lowSat = (&lowCnt_reg) ? lowCnt_reg : lowCnt_reg + 1'b1;
   wire [CNT_W-1:0] highSat = (&highCnt_reg) ? highCnt_reg : highCnt_reg + 1'b1;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         syncA_reg <= 1'b1;
         syncB_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         syncA_reg <= line.lineLevel;
         syncB_reg <= syncA_reg;
         prev_reg <= syncB_reg;
      end
   end

   // consecutive low time of the line, saturating
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         lowRun_reg <= '0;
      end else if (lineNow) begin
         lowRun_reg <= '0;
      end else if (!(&lowRun_reg)) begin
         lowRun_reg <= lowRun_reg + 1'b1;
      end
   end

   always_comb begin
      state_next = state_reg;
      lowCnt_next = lowCnt_reg;
      highCnt_next = highCnt_reg;
      timer_next = timer_reg;
      bitCnt_next = bitCnt_reg;
      shift_next = shift_reg;
      err_next = err_reg;
      level_next = level_reg;
      frameOk_next = 1'b0;
      case (state_reg)
         OWD_IDLE: begin
            // first fall opens the address byte, start condition optional
            if (fallEdge) begin
               state_next = OWD_BIT;
               lowCnt_next = '0;
               highCnt_next = '0;
               bitCnt_next = '0;
               err_next = 1'b0;
            end
         end
         OWD_BIT: begin
            if (fallEdge) begin
               shift_next = shiftIn;
               err_next = errWithBit;
               bitCnt_next = bitCntInc;
               lowCnt_next = '0;
               highCnt_next = '0;
               if (frameDone) begin
                  if (frameGood) begin
                     level_next = shiftIn[LEVEL_MSB:0];
                     frameOk_next = 1'b1;
                  end
                  timer_next = '0;
                  state_next = ackWanted ? OWD_ACKWAIT : OWD_IDLE;
               end else if (byteDone) begin
                  state_next = OWD_EOS;
               end
            end else if (lineNow) begin
               highCnt_next = highSat;
            end else begin
               lowCnt_next = lowSat;
            end
         end
         OWD_EOS: begin
            // byte boundary must stay low long enough
            if (riseEdge && eosShort) begin
               err_next = 1'b1;
            end
            // high time before this fall is the host's start condition
            if (fallEdge) begin
               state_next = OWD_BIT;
            end
         end
         OWD_ACKWAIT: begin
            // host still holds the line low here
            timer_next = timer_reg + 1'b1;
            if (delayDone) begin
               timer_next = '0;
               state_next = OWD_ACK;
            end
         end
         OWD_ACK: begin
            timer_next = timer_reg + 1'b1;
            if (pulseDone) begin
               state_next = OWD_IDLE;
            end
         end
         OWD_SHUT: begin
            if (riseEdge) begin
               state_next = OWD_IDLE;
            end
         end
         default: begin
            state_next = OWD_IDLE;
         end
      endcase
      // own pulldown is excluded: the ack pulse is shorter than shutdown anyway
      if (longLow && state_reg != OWD_ACK && state_reg != OWD_SHUT) begin
         state_next = OWD_SHUT;
         frameOk_next = 1'b0;
         level_next = level_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= OWD_IDLE;
         lowCnt_reg <= '0;
         highCnt_reg <= '0;
         timer_reg <= '0;
         bitCnt_reg <= '0;
         shift_reg <= '0;
         err_reg <= 1'b0;
         level_reg <= LEVEL_RESET;
         frameOk_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         lowCnt_reg <= lowCnt_next;
         highCnt_reg <= highCnt_next;
         timer_reg <= timer_next;
         bitCnt_reg <= bitCnt_next;
         shift_reg <= shift_next;
         err_reg <= err_next;
         level_reg <= level_next;
         frameOk_reg <= frameOk_next;
      end
   end

   // open drain: only ever pulls low, logic 0 means acknowledged
   assign line.devOe = state_reg == OWD_ACK;
   assign ackActive = state_reg == OWD_ACK;
   assign shutdownMode = state_reg == OWD_SHUT;
   assign level = level_reg;
   assign frameOk = frameOk_reg;
endmodule

// *** pkg/owd_pkg.sv ***
/*
 * Shared constants for the one-wire dimming link: timing, frame layout,
 * field positions and reset values.
 * Assumes a single 200 MHz system clock on both ends of the link.
 */
package owd_pkg;
   localparam int CLK_MHZ = 200;
   localparam int CNT_W = 20;

   localparam int T_START_NS = 2000;
   localparam int END_OF_STREAM_TIME_NS = 2000;
   localparam int T_ACK_DELAY_NS = 4000;
   localparam int T_ACK_PULSE_US = 512;
   localparam int T_SHUT_US = 2500;
   localparam int T_HOST_BIT_NS = 20000;

   // least times round up, longest times round down
   localparam int START_CYC = (T_START_NS * CLK_MHZ + 999) / 1000;
   localparam int EOS_CYC = (END_OF_STREAM_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int ACK_DELAY_CYC = (T_ACK_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int ACK_PULSE_CYC = T_ACK_PULSE_US * CLK_MHZ;
   localparam int SHUT_CYC = T_SHUT_US * CLK_MHZ;
   localparam int HOST_BIT_CYC = (T_HOST_BIT_NS * CLK_MHZ + 999) / 1000;
   localparam int HOST_ACK_MARGIN_CYC = 16;
   localparam int HOST_SAMPLE_CYC = 8;

   localparam int BYTE_BITS = 8;
   localparam int FRAME_BITS = 16;
   localparam int ACK_REQ_BIT = 7;
   localparam int SUB_HI_BIT = 6;
   localparam int SUB_LO_BIT = 5;
   localparam int LEVEL_MSB = 4;
   localparam int LEVEL_W = 5;
   localparam logic [4:0] LEVEL_RESET = 5'h1F;
   // arbitrary identity value, not taken from any part
   localparam logic [7:0] DEV_ADDR_DEFAULT = 8'h5A;
endpackage

// *** pkg/owd_if.sv ***
/*
 * Single control line between host and dimming receiver.
 * Assumes an external pullup: the line is high unless a party pulls it low.
 */
`timescale 1ns/10ps
interface owd_if;
   logic hostOut;
   logic hostOe;
   logic devOe;
   logic lineLevel;

   // device side is open drain only; a push-pull host low also wins
   assign lineLevel = !(devOe | (hostOe & !hostOut));

   modport dev(input lineLevel, output devOe);
   modport host(input lineLevel, output hostOut, hostOe);
endinterface

// *** core/owd_host.sv ***
/*
 * Host end of the one-wire dimming link: sends address and data bytes,
 * optionally requests and samples the acknowledge.
 * Assumes the line is shared through owd_if with an external pullup.
 */
`timescale 1ns/10ps
module owd_host
   import owd_pkg::*;
#(
   parameter bit OPEN_DRAIN = 1'b1,
   parameter logic [7:0] DEV_ADDR = DEV_ADDR_DEFAULT,
   parameter int BIT_TIME = HOST_BIT_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   owd_if.host line,
   input wire logic sendReq,
   input wire logic [LEVEL_W-1:0] sendLevel,
   input wire logic sendAck,
   output logic busy,
   output logic done,
   output logic acked
);
   typedef enum logic [2:0] {OWH_IDLE, OWH_START, OWH_LOW, OWH_HIGH, OWH_EOS, OWH_ACKHOLD, OWH_SAMPLE,
                             OWH_WAITEND} owd_hstate_t;

   localparam int ONE_LOW = BIT_TIME / 4;
   localparam int ZERO_LOW = BIT_TIME - ONE_LOW;

   owd_hstate_t state_reg, state_next;
   logic syncA_reg, syncB_reg;
   logic [CNT_W-1:0] timer_reg, timer_next;
   logic [4:0] bitCnt_reg, bitCnt_next;
   logic [FRAME_BITS-1:0] word_reg, word_next;
   logic want_reg, want_next;
   logic done_reg, done_next;
   logic acked_reg, acked_next;
   logic ackReq_reg, ackReq_next;

   // a push-pull driver cannot coexist with the device pulldown
   wire reqAck = OPEN_DRAIN & sendAck;
   wire curBit = word_reg[FRAME_BITS-1];
   wire [CNT_W-1:0] lowLen = curBit ? CNT_W'(ONE_LOW) : CNT_W'(ZERO_LOW);
   wire [CNT_W-1:0] highLen = CNT_W'(BIT_TIME) - lowLen;
   wire [4:0] bitCntInc = bitCnt_reg + 5'h01;
   wire [CNT_W-1:0] timerInc = timer_reg + 1'b1;
   wire idleLong = timer_reg >= CNT_W'(START_CYC);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         syncA_reg <= 1'b1;
         syncB_reg <= 1'b1;
      end else begin
         syncA_reg <= line.lineLevel;
         syncB_reg <= syncA_reg;
      end
   end

   always_comb begin
      state_next = state_reg;
      timer_next = timerInc;
      bitCnt_next = bitCnt_reg;
      word_next = word_reg;
      want_next = want_reg;
      done_next = 1'b0;
      acked_next = acked_reg;
      ackReq_next = ackReq_reg;
      case (state_reg)
         OWH_IDLE: begin
            want_next = 1'b1;
            // idle high time saturates at one start condition
            if (idleLong) begin
               timer_next = timer_reg;
            end
            if (sendReq) begin
               word_next = {DEV_ADDR, reqAck, 2'b00, sendLevel};
               // latched: the flag sent and the ack handling must agree
               ackReq_next = reqAck;
               bitCnt_next = '0;
               acked_next = 1'b0;
               if (idleLong) begin
                  // line already high long enough, address needs no start
                  timer_next = '0;
                  want_next = 1'b0;
                  state_next = OWH_LOW;
               end else begin
                  state_next = OWH_START;
               end
            end
         end
         OWH_START: begin
            want_next = 1'b1;
            if (timerInc >= CNT_W'(START_CYC)) begin
               timer_next = '0;
               want_next = 1'b0;
               state_next = OWH_LOW;
            end
         end
         OWH_LOW: begin
            if (timerInc == lowLen) begin
               timer_next = '0;
               want_next = 1'b1;
               state_next = OWH_HIGH;
            end
         end
         OWH_HIGH: begin
            if (timerInc == highLen) begin
               timer_next = '0;
               want_next = 1'b0;
               word_next = {word_reg[FRAME_BITS-2:0], 1'b0};
               bitCnt_next = bitCntInc;
               if (bitCntInc == 5'(BYTE_BITS) || bitCntInc == 5'(FRAME_BITS)) begin
                  state_next = OWH_EOS;
               end else begin
                  state_next = OWH_LOW;
               end
            end
         end
         OWH_EOS: begin
            if (timerInc == CNT_W'(EOS_CYC)) begin
               timer_next = '0;
               want_next = 1'b1;
               if (bitCnt_reg != 5'(FRAME_BITS)) begin
                  state_next = OWH_START;
               end else if (ackReq_reg) begin
                  want_next = 1'b0;
                  state_next = OWH_ACKHOLD;
               end else begin
                  done_next = 1'b1;
                  state_next = OWH_IDLE;
               end
            end
         end
         OWH_ACKHOLD: begin
            // low past the device delay plus its input latency
            if (timerInc == CNT_W'(ACK_DELAY_CYC + HOST_ACK_MARGIN_CYC - EOS_CYC)) begin
               timer_next = '0;
               want_next = 1'b1;
               state_next = OWH_SAMPLE;
            end
         end
         OWH_SAMPLE: begin
            if (timerInc == CNT_W'(HOST_SAMPLE_CYC)) begin
               acked_next = !syncB_reg;
               state_next = OWH_WAITEND;
            end
         end
         OWH_WAITEND: begin
            if (syncB_reg) begin
               timer_next = '0;
               done_next = 1'b1;
               state_next = OWH_IDLE;
            end
         end
         default: begin
            state_next = OWH_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= OWH_IDLE;
         timer_reg <= '0;
         bitCnt_reg <= '0;
         word_reg <= '0;
         want_reg <= 1'b1;
         done_reg <= 1'b0;
         acked_reg <= 1'b0;
         ackReq_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         bitCnt_reg <= bitCnt_next;
         word_reg <= word_next;
         want_reg <= want_next;
         done_reg <= done_next;
         acked_reg <= acked_next;
         ackReq_reg <= ackReq_next;
      end
   end

   assign line.hostOut = want_reg;
   assign line.hostOe = OPEN_DRAIN ? !want_reg : 1'b1;
   assign busy = state_reg != OWH_IDLE;
   assign done = done_reg;
   assign acked = acked_reg;
endmodule

// *** bench/owd_monitor.sv ***
/*
 * Checker on the host-to-receiver link signals.
 * Assumes it is instantiated beside the link interface in the bench top.
 */
`timescale 1ns/10ps
module owd_monitor
   import owd_pkg::*;
#(
   parameter int ACK_PULSE = ACK_PULSE_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic hostOut,
   input wire logic hostOe,
   input wire logic devOe,
   input wire logic lineLevel
);
   wire hostLow;
   logic [19:0] loCnt_reg, hiCnt_reg, lastLo_reg, ackCnt_reg, fallCnt_reg;
   logic lineD_reg;
   assign hostLow = hostOe & !hostOut;
   // saturate so long idle spans never wrap
   function automatic logic [19:0] sat(input logic [19:0] v);
      return (v == '1) ? v : v + 20'h1;
   endfunction
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         {loCnt_reg, hiCnt_reg, lastLo_reg, ackCnt_reg, fallCnt_reg} <= '0;
         lineD_reg <= 1'b1;
      end else begin
         loCnt_reg <= hostLow ? sat(loCnt_reg) : '0;
         hiCnt_reg <= hostLow ? '0 : sat(hiCnt_reg);
         if (!hostLow && loCnt_reg != '0) lastLo_reg <= loCnt_reg;
         ackCnt_reg <= devOe ? sat(ackCnt_reg) : '0;
         fallCnt_reg <= (lineD_reg && !lineLevel) ? '0 : sat(fallCnt_reg);
         lineD_reg <= lineLevel;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_hold;
      hostLow [*4];
   endsequence
   sequence s_release;
      ##[1:64] !hostLow;
   endsequence
   AST_ACK_OPEN_DRAIN: assert property (devOe |-> !(hostOe && hostOut))
      else $error("host drives high against pulldown");
   AST_ACK_LEN: assert property ($fell(devOe) |-> ackCnt_reg == ACK_PULSE)
      else $error("ack pulse length wrong");
   AST_ACK_DELAY: assert property ($rose(devOe) |-> fallCnt_reg >= ACK_DELAY_CYC && fallCnt_reg <= ACK_DELAY_CYC + 10)
      else $error("ack pulse started at wrong time");
   AST_HOST_HOLD: assert property ($rose(devOe) |-> s_hold)
      else $error("host not holding line at ack start");
   AST_HOST_RELEASE: assert property ($rose(devOe) |-> s_release)
      else $error("host did not release for ack");
   AST_NO_NEW_TX: assert property (devOe && !hostLow |=> !hostLow || !devOe)
      else $error("host drove line during ack pulse");
   AST_BIT_RATIO: assert property ($rose(hostLow) && lastLo_reg != 0 && lastLo_reg < EOS_CYC && hiCnt_reg < START_CYC
      |-> hiCnt_reg >= 2 * lastLo_reg || lastLo_reg >= 2 * hiCnt_reg)
      else $error("bit ratio below two to one");
   AST_EOS_LEN: assert property ($rose(hostLow) && hiCnt_reg >= START_CYC && lastLo_reg != 0
      |-> lastLo_reg >= EOS_CYC)
      else $error("end of stream too short");
   AST_START_LEN: assert property ($rose(hostLow) && lastLo_reg >= EOS_CYC |-> hiCnt_reg >= START_CYC)
      else $error("start condition too short");
endmodule

// *** bench/one_wire_dimming_receiver_tb_top.sv ***
/*
 * Bench top: host and receiver on one link, a push-pull pair on a second,
 * a third receiver on a raw line driven by the bench for framing faults.
 * Assumes package and link interface are compiled first.
 */
`timescale 1ns/10ps
module one_wire_dimming_receiver_tb_top
   import owd_pkg::*;
;
   localparam int APULSE = 200;
   localparam int SHUT = 2000;
   localparam logic [7:0] DA = DEV_ADDR_DEFAULT;
   logic ref_clk, resetn, sendReq, sendAck, busy, done, acked, frameOk, shutB, ackB, busyP, ackedP, ackP;
   logic [LEVEL_W-1:0] sendLevel, level, levelB, levelP;
   int error_cnt, n_checks, okCnt, ppAckCnt, eosLen;
   owd_if u_owd_if();
   owd_if u_owd_if_raw();
   owd_if u_owd_if_pp();
   owd_host #(.BIT_TIME(400)) u_owd_host (.ref_clk(ref_clk), .resetn(resetn), .line(u_owd_if.host),
      .sendReq(sendReq), .sendLevel(sendLevel), .sendAck(sendAck), .busy(busy), .done(done), .acked(acked));
   owd_device #(.ACK_PULSE(APULSE), .SHUT_TIME(SHUT)) u_owd_device (.ref_clk(ref_clk), .resetn(resetn),
      .line(u_owd_if.dev), .level(level), .shutdownMode(), .frameOk(frameOk), .ackActive());
   owd_device #(.ACK_PULSE(APULSE), .SHUT_TIME(SHUT)) u_owd_device_raw (.ref_clk(ref_clk), .resetn(resetn),
      .line(u_owd_if_raw.dev), .level(levelB), .shutdownMode(shutB), .frameOk(), .ackActive(ackB));
   // push-pull host fed the same requests; it must never ask for acknowledge
   owd_host #(.OPEN_DRAIN(1'b0), .BIT_TIME(400)) u_owd_host_pp (.ref_clk(ref_clk), .resetn(resetn),
      .line(u_owd_if_pp.host), .sendReq(sendReq), .sendLevel(sendLevel), .sendAck(sendAck), .busy(busyP),
      .done(), .acked(ackedP));
   owd_device #(.ACK_PULSE(APULSE), .SHUT_TIME(SHUT)) u_owd_device_pp (.ref_clk(ref_clk), .resetn(resetn),
      .line(u_owd_if_pp.dev), .level(levelP), .shutdownMode(), .frameOk(), .ackActive(ackP));
   owd_monitor #(.ACK_PULSE(APULSE)) u_owd_monitor (.ref_clk(ref_clk), .resetn(resetn),
      .hostOut(u_owd_if.hostOut), .hostOe(u_owd_if.hostOe), .devOe(u_owd_if.devOe),
      .lineLevel(u_owd_if.lineLevel));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (frameOk === 1'b1) okCnt++;
   always @(posedge ref_clk) if (ackP === 1'b1) ppAckCnt++;
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic host_send(input logic [4:0] lv, input logic ak);
      int n;
      int ok0;
      ok0 = okCnt;
      sendLevel = lv;
      sendAck = ak;
      sendReq = 1'b1;
      tick(1);
      sendReq = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         tick(1);
         n++;
      end
      chk({7'h0, done}, 8'h01);
      chk({3'h0, level}, {3'h0, lv});
      chk({7'h0, acked}, {7'h0, ak});
      chk(8'(okCnt - ok0), 8'h01);
      chk({1'b0, busyP, ackedP, levelP}, {3'h0, lv});
      chk(8'(ppAckCnt), 8'h00);
   endtask
   // pull low on the raw line; bench host is open drain
   task automatic pull(input logic v);
      u_owd_if_raw.hostOe = v;
   endtask
   task automatic raw_bit(input logic b, input int bl, input bit bad);
      int lo;
      lo = bad ? bl / 2 : (b ? bl / 4 : 3 * bl / 4);
      pull(1'b1);
      tick(lo);
      pull(1'b0);
      tick(bl - lo);
   endtask
   task automatic raw_frame(input logic [15:0] f, input int bl, input int badIdx, input bit full);
      for (int i = 15; i >= 8; i--) raw_bit(f[i], bl, i == badIdx);
      if (full) begin
         pull(1'b1);
         tick(eosLen);
         pull(1'b0);
         tick(START_CYC);
         for (int i = 7; i >= 0; i--) raw_bit(f[i], bl, i == badIdx);
         // hold low through the ack delay, then let go and sample
         pull(1'b1);
         tick(ACK_DELAY_CYC + HOST_ACK_MARGIN_CYC);
         pull(1'b0);
         tick(HOST_SAMPLE_CYC);
      end
   endtask
   task automatic raw_check(input logic [4:0] lv, input logic ak);
      int n;
      chk({6'h0, ackB, u_owd_if_raw.lineLevel}, {6'h0, ak, !ak});
      n = 0;
      while (u_owd_if_raw.lineLevel !== 1'b1 && n < APULSE + 50) begin
         tick(1);
         n++;
      end
      chk({7'h0, u_owd_if_raw.lineLevel}, 8'h01);
      chk({3'h0, levelB}, {3'h0, lv});
      tick(20);
   endtask
   initial begin
      tick(90000);
      error_cnt++;
      $display("watchdog expired");
      give_verdict();
   end
   initial begin
      resetn = 1'b0;
      sendReq = 1'b0;
      sendLevel = 5'h00;
      sendAck = 1'b0;
      u_owd_if_raw.hostOut = 1'b0;
      u_owd_if_raw.hostOe = 1'b0;
      eosLen = EOS_CYC;
      tick(2);
      resetn = 1'b1;
      chk({3'h0, level}, {3'h0, LEVEL_RESET});
      chk({3'h0, levelB}, {3'h0, LEVEL_RESET});
      chk({5'h0, busy, acked, shutB}, 8'h00);
      $display("test reset_values done");
      host_send(5'h03, 1'b1);
      host_send(5'h1C, 1'b0);
      // long idle high lets the host skip the start condition
      tick(START_CYC + 20);
      host_send(5'h15, 1'b1);
      $display("test host_frames done");
      resetn = 1'b0;
      tick(2);
      resetn = 1'b1;
      chk({3'h0, level}, {3'h0, LEVEL_RESET});
      $display("test mid_reset done");
      raw_frame({DA, 8'h83}, 200, 99, 1'b1);
      raw_check(5'h03, 1'b1);
      raw_frame({~DA, 8'h9C}, 200, 99, 1'b1);
      raw_check(5'h03, 1'b0);
      raw_frame({DA, 8'hBC}, 200, 99, 1'b1);
      raw_check(5'h03, 1'b0);
      raw_frame({DA, 8'h9C}, 200, 4, 1'b1);
      raw_check(5'h03, 1'b0);
      eosLen = EOS_CYC - 50;
      raw_frame({DA, 8'h9C}, 200, 99, 1'b1);
      eosLen = EOS_CYC;
      raw_check(5'h03, 1'b0);
      $display("test raw_refusals done");
      raw_frame({DA, 8'h9C}, 200, 99, 1'b0);
      pull(1'b1);
      tick(SHUT + 100);
      chk({7'h0, shutB}, 8'h01);
      pull(1'b0);
      tick(20);
      chk({7'h0, shutB}, 8'h00);
      chk({3'h0, levelB}, 8'h03);
      $display("test shutdown done");
      raw_frame({DA, 8'h1C}, 800, 99, 1'b1);
      raw_check(5'h1C, 1'b0);
      raw_frame({DA, 8'h85}, 40, 99, 1'b1);
      raw_check(5'h05, 1'b1);
      $display("test bit_rates done");
      give_verdict();
   end
endmodule
